// file: src/scc_pkg.sv
// shared constants and types for the section call and context unit
package scc_pkg;
   localparam int WORD_W = 16;
   localparam int SEC_W = 8;
   localparam int LVL_W = 5;
   // fixed address of the pointer to the monitor's section relocation table
   localparam logic [15:0] MON_RELOC_PTR_ADDR = 16'h000C;
   // each relocation pair is four bytes
   localparam int RELOC_STRIDE_SHIFT = 2;
   // device deactivation table and context pointer table sizes
   localparam int DEV_TABLE_WORDS = 32;
   localparam int CTX_PTR_WORDS = 32;
   // interrupt configuration field inside a deactivation word
   localparam int IRQ_CFG_LSB = 3;
   localparam int IRQ_CFG_MSB = 15;
   // context layout word indices
   localparam int CTX_WORDS = 7;
   localparam int CTX_STATUS = 0;
   localparam int CTX_X = 1;
   localparam int CTX_E = 2;
   localparam int CTX_A = 3;
   localparam int CTX_G = 4;
   localparam int CTX_L = 5;
   localparam int CTX_P = 6;
   // task work area size and the slots used for a supervisor call save
   localparam int TWA_WORDS = 16;
   localparam logic [15:0] TWA_P_OFS = 16'h0000;
   localparam logic [15:0] TWA_L_OFS = 16'h0002;
   localparam logic [15:0] TWA_IND_OFS = 16'h0004;
   // status indicator bit positions
   localparam int IND_PROT = 0;
   localparam int IND_MASTER = 1;
   localparam logic MASTER_MODE = 1'b1;
   localparam logic SLAVE_MODE = 1'b0;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   typedef enum logic [2:0] {
      SCC_OP_NONE,
      SCC_OP_CALL,
      SCC_OP_RET,
      SCC_OP_SVC,
      SCC_OP_SVR,
      SCC_OP_ACT,
      SCC_OP_SAVE
   } scc_op_type;
endpackage

// file: src/scc_unit.sv
// section call, supervisor call and task context switch sequencer
//
// Functional notes
// RL1: section call stores P-G and L-G into first two words of callee data.
// RL2: section call then loads P and L from callee entry and data addresses.
// RL3: section return reloads P and L from first two words of data area.
// RL4: section return adds general base back to both restored values.
// RL5: relocation pair holds initial L then P, both relative to G.
// RL6: relocation pair of section n sits at G minus four n.
// RL7: monitor relocation table pointer is read from address 12.
// RL8: deactivation table of 32 words directly precedes context pointer table.
// RL9: deactivation word bits 3..15 form the interrupt configuration field.
// RL10: context is status, X, E, A, G, L, P in seven consecutive words.
// RL11: level activation fetches pointer, loads context, resumes at loaded P.
// RL12: preemption or acknowledge stores registers and status into context.
// RL13: caller reserves a 16-word task work area at start of common data.
// RL14: supervisor call keeps priority level and runs in master mode.
// RL15: supervisor call keeps G and saves relative to it.
// RL16: system sections run with local base zero.
// RL17: supervisor return reloads L and P from caller task work area.
// RL18: supervisor return restores caller master or slave mode.
// RL19: supervisor call saves protect key, forces one, return restores it.
// RL20: master mode is mode flag one, slave mode is zero.
`timescale 1ns/1ps
module scc_unit
#(
   parameter logic [15:0] DEV_TABLE_BASE = 16'h0040
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic start,
   input wire scc_pkg::scc_op_type op,
   input wire logic [scc_pkg::SEC_W-1:0] section_num,
   input wire logic [scc_pkg::LVL_W-1:0] level_num,
   input wire logic [15:0] cur_p,
   input wire logic [15:0] cur_l,
   input wire logic [15:0] cur_g,
   input wire logic [15:0] cur_a,
   input wire logic [15:0] cur_e,
   input wire logic [15:0] cur_x,
   input wire logic [15:0] cur_ind,
   output logic mem_req,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   output logic busy,
   output logic done,
   output logic [15:0] new_p,
   output logic [15:0] new_l,
   output logic [15:0] new_g,
   output logic [15:0] new_a,
   output logic [15:0] new_e,
   output logic [15:0] new_x,
   output logic [15:0] new_ind,
   output logic [12:0] irq_config
);
   import scc_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE, ST_PTR, ST_RELOC, ST_WRITE, ST_READ, ST_DVT, ST_FINISH
   } scc_state_type;

   // byte address of relocation pair n below base g
   function automatic logic [15:0] reloc_addr(input logic [15:0] g,
                                              input logic [SEC_W-1:0] n);
      reloc_addr = g - (16'(n) << RELOC_STRIDE_SHIFT); // RL6
   endfunction

   scc_state_type st_q, st_d;
   scc_op_type op_q, op_d;
   logic [2:0] idx_q, idx_d;
   logic [15:0] rel_l_q, rel_l_d;
   logic [LVL_W-1:0] lvl_q, lvl_d;
   logic [15:0] sv [CTX_WORDS];
   logic [15:0] rv_q [CTX_WORDS];
   logic [15:0] rv_d [CTX_WORDS];
   logic req_q, req_d, we_q, we_d, busy_q, busy_d, done_q, done_d;
   logic [15:0] addr_q, addr_d, wd_q, wd_d;
   logic [12:0] irqc_q, irqc_d;

   // current register image in context order
   always_comb begin
      sv[CTX_STATUS] = cur_ind; // RL10
      sv[CTX_X] = cur_x;
      sv[CTX_E] = cur_e;
      sv[CTX_A] = cur_a;
      sv[CTX_G] = cur_g;
      sv[CTX_L] = cur_l;
      sv[CTX_P] = cur_p;
   end

   // sequencer next state: one memory word per handshake
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      idx_d = idx_q;
      rel_l_d = rel_l_q;
      lvl_d = lvl_q;
      rv_d = rv_q;
      req_d = req_q;
      we_d = we_q;
      addr_d = addr_q;
      wd_d = wd_q;
      busy_d = busy_q;
      done_d = 1'b0;
      irqc_d = irqc_q;
      unique case (st_q)
         ST_IDLE: begin
            if (start && op != SCC_OP_NONE) begin
               op_d = op;
               lvl_d = level_num;
               busy_d = 1'b1;
               idx_d = 3'd0;
               rv_d = sv;
               req_d = 1'b1;
               we_d = 1'b0;
               unique case (op)
                  SCC_OP_CALL: begin
                     addr_d = reloc_addr(cur_g, section_num); // RL6
                     st_d = ST_RELOC;
                  end
                  SCC_OP_RET: begin
                     addr_d = cur_l; // RL3
                     st_d = ST_READ;
                  end
                  SCC_OP_SVC: begin
                     addr_d = MON_RELOC_PTR_ADDR; // RL7
                     st_d = ST_PTR;
                  end
                  SCC_OP_SVR: begin
                     addr_d = cur_g + TWA_P_OFS; // RL17
                     st_d = ST_READ;
                  end
                  SCC_OP_ACT, SCC_OP_SAVE: begin
                     // deactivation table first, pointer table right after it
                     addr_d = DEV_TABLE_BASE + 16'({level_num, 1'b0}); // RL8
                     st_d = ST_DVT;
                  end
                  default: begin
                     req_d = 1'b0;
                     busy_d = 1'b0;
                     st_d = ST_IDLE;
                  end
               endcase
            end
         end
         ST_DVT: if (mem_ack) begin
            if (idx_q == 3'd0) begin
               irqc_d = mem_rdata[IRQ_CFG_MSB:IRQ_CFG_LSB]; // RL9
               idx_d = 3'd1;
               addr_d = DEV_TABLE_BASE + 16'(DEV_TABLE_WORDS * 2)
                        + 16'({lvl_q, 1'b0}); // RL8
            end else begin
               // the context pointer is the address of the first context word
               idx_d = 3'd0;
               addr_d = mem_rdata; // RL11
               if (op_q == SCC_OP_SAVE) begin
                  we_d = 1'b1;
                  wd_d = rv_q[0]; // RL12
                  st_d = ST_WRITE;
               end else begin
                  st_d = ST_READ;
               end
            end
         end
         ST_PTR: if (mem_ack) begin
            // monitor table base, then its relocation pair
            addr_d = reloc_addr(mem_rdata, section_num);
            st_d = ST_RELOC;
         end
         ST_RELOC: if (mem_ack) begin
            if (idx_q == 3'd0) begin
               rel_l_d = mem_rdata; // RL5
               idx_d = 3'd1;
               addr_d = addr_q + WORD_STEP;
            end else begin
               idx_d = 3'd0;
               we_d = 1'b1;
               if (op_q == SCC_OP_CALL) begin
                  rv_d[CTX_P] = cur_g + mem_rdata; // RL2
                  rv_d[CTX_L] = cur_g + rel_l_q; // RL2
                  addr_d = cur_g + rel_l_q;
                  wd_d = cur_p - cur_g; // RL1
               end else begin
                  rv_d[CTX_P] = mem_rdata;
                  rv_d[CTX_L] = ZERO_WORD; // RL16
                  rv_d[CTX_G] = cur_g; // RL15
                  rv_d[CTX_STATUS][IND_MASTER] = MASTER_MODE; // RL14 RL20
                  rv_d[CTX_STATUS][IND_PROT] = 1'b1; // RL19
                  addr_d = cur_g + TWA_P_OFS; // RL15
                  wd_d = cur_p - cur_g;
               end
               st_d = ST_WRITE;
            end
         end
         ST_WRITE: if (mem_ack) begin
            idx_d = idx_q + 3'd1;
            addr_d = addr_q + WORD_STEP;
            unique case (op_q)
               SCC_OP_CALL: begin
                  wd_d = cur_l - cur_g; // RL1
                  if (idx_q == 3'd1) st_d = ST_FINISH;
               end
               SCC_OP_SVC: begin
                  // caller indicators carry the saved protect key and mode
                  wd_d = (idx_q == 3'd0) ? cur_l - cur_g : cur_ind; // RL19
                  if (idx_q == 3'd2) st_d = ST_FINISH;
               end
               default: begin
                  // the image has seven words, so never index past the last one
                  if (idx_q == 3'(CTX_WORDS - 1)) st_d = ST_FINISH;
                  else wd_d = rv_q[3'(idx_q + 3'd1)]; // RL12
               end
            endcase
            if (st_d == ST_FINISH) begin
               req_d = 1'b0;
               we_d = 1'b0;
            end
         end
         ST_READ: if (mem_ack) begin
            idx_d = idx_q + 3'd1;
            addr_d = addr_q + WORD_STEP;
            unique case (op_q)
               SCC_OP_RET: begin
                  if (idx_q == 3'd0) rv_d[CTX_P] = mem_rdata + cur_g; // RL4
                  else rv_d[CTX_L] = mem_rdata + cur_g; // RL4
                  if (idx_q == 3'd1) st_d = ST_FINISH;
               end
               SCC_OP_SVR: begin
                  if (idx_q == 3'd0) rv_d[CTX_P] = mem_rdata + cur_g; // RL17
                  else if (idx_q == 3'd1) rv_d[CTX_L] = mem_rdata + cur_g;
                  else begin
                     rv_d[CTX_STATUS][IND_MASTER] = mem_rdata[IND_MASTER]; // RL18
                     rv_d[CTX_STATUS][IND_PROT] = mem_rdata[IND_PROT]; // RL19
                  end
                  if (idx_q == 3'd2) st_d = ST_FINISH;
               end
               default: begin
                  rv_d[idx_q] = mem_rdata; // RL11
                  if (idx_q == 3'(CTX_WORDS - 1)) st_d = ST_FINISH;
               end
            endcase
            if (st_d == ST_FINISH) req_d = 1'b0;
         end
         ST_FINISH: begin
            busy_d = 1'b0;
            done_d = 1'b1;
            st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // registers of the sequencer
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_IDLE;
         op_q <= SCC_OP_NONE;
         idx_q <= 3'd0;
         rel_l_q <= 16'h0000;
         lvl_q <= '0;
         for (int i = 0; i < CTX_WORDS; i++) begin
            rv_q[i] <= 16'h0000;
         end
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 16'h0000;
         wd_q <= 16'h0000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         irqc_q <= 13'h0000;
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         idx_q <= idx_d;
         rel_l_q <= rel_l_d;
         lvl_q <= lvl_d;
         rv_q <= rv_d;
         req_q <= req_d;
         we_q <= we_d;
         addr_q <= addr_d;
         wd_q <= wd_d;
         busy_q <= busy_d;
         done_q <= done_d;
         irqc_q <= irqc_d;
      end
   end

   // outputs straight from flip-flops
   assign mem_req = req_q;
   assign mem_we = we_q;
   assign mem_addr = addr_q;
   assign mem_wdata = wd_q;
   assign busy = busy_q;
   assign done = done_q;
   assign new_p = rv_q[CTX_P];
   assign new_l = rv_q[CTX_L];
   assign new_g = rv_q[CTX_G];
   assign new_a = rv_q[CTX_A];
   assign new_e = rv_q[CTX_E];
   assign new_x = rv_q[CTX_X];
   assign new_ind = rv_q[CTX_STATUS];
   assign irq_config = irqc_q;

   // checks kept next to the sequencer
   a_call_save_p: assert property (@(posedge clk_sys) disable iff (!nrst) // RL1
      (st_q == ST_WRITE && op_q == SCC_OP_CALL && idx_q == 3'd0)
      |-> mem_wdata == cur_p - cur_g)
      else $error("call saved wrong program counter");
   a_svc_master: assert property (@(posedge clk_sys) disable iff (!nrst) // RL14
      (done && op_q == SCC_OP_SVC) |-> new_ind[IND_MASTER] == MASTER_MODE)
      else $error("supervisor call not in master mode");
   a_svc_key: assert property (@(posedge clk_sys) disable iff (!nrst) // RL19
      (done && op_q == SCC_OP_SVC) |-> new_ind[IND_PROT])
      else $error("protect key not forced");
   a_svc_zero_l: assert property (@(posedge clk_sys) disable iff (!nrst) // RL16
      (done && op_q == SCC_OP_SVC) |-> new_l == 16'h0000 && new_g == cur_g)
      else $error("system section base wrong");
   a_svc_ptr: assert property (@(posedge clk_sys) disable iff (!nrst) // RL7
      (st_q == ST_PTR) |-> mem_addr == MON_RELOC_PTR_ADDR)
      else $error("monitor table pointer address wrong");
   a_reloc_addr: assert property (@(posedge clk_sys) disable iff (!nrst) // RL6
      (st_q == ST_IDLE && start && op == SCC_OP_CALL)
      |=> mem_addr == $past(cur_g) - {$past(section_num), 2'b00})
      else $error("relocation pair address wrong");
   a_ret_done: assert property (@(posedge clk_sys) disable iff (!nrst) // RL3
      (st_q == ST_IDLE && start && op == SCC_OP_RET) |-> ##[3:40] done)
      else $error("section return never completed");
   a_ctx_len: assert property (@(posedge clk_sys) disable iff (!nrst) // RL12
      (st_q == ST_WRITE && op_q == SCC_OP_SAVE)
      |-> mem_we && idx_q < 3'(CTX_WORDS) && mem_wdata == sv[idx_q])
      else $error("context save word out of order");
   a_call_save_l: assert property (@(posedge clk_sys) disable iff (!nrst) // RL1
      (st_q == ST_WRITE && op_q == SCC_OP_CALL && idx_q == 3'd1)
      |-> mem_wdata == cur_l - cur_g)
      else $error("call saved wrong local base");
   a_ret_addr: assert property (@(posedge clk_sys) disable iff (!nrst) // RL3
      (st_q == ST_IDLE && start && op == SCC_OP_RET)
      |=> mem_addr == $past(cur_l) && !mem_we)
      else $error("section return read from wrong address");
   a_dvt_ptr: assert property (@(posedge clk_sys) disable iff (!nrst) // RL8
      (st_q == ST_DVT && idx_q == 3'd0 && mem_ack)
      |=> mem_addr == $past(mem_addr) + 16'(DEV_TABLE_WORDS * 2))
      else $error("pointer table not right after deactivation table");
   a_irq_field: assert property (@(posedge clk_sys) disable iff (!nrst) // RL9
      (st_q == ST_DVT && idx_q == 3'd0 && mem_ack)
      |=> irq_config == ($past(mem_rdata) >> IRQ_CFG_LSB))
      else $error("interrupt configuration field wrong");
endmodule

// file: sim/scc_mem_model.sv
// core memory partner holding relocation tables, task work areas and contexts
`timescale 1ns/1ps
module scc_mem_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic [3:0] stall,
   output logic mem_ack,
   output logic [15:0] mem_rdata
);
   // word array indexed by byte address over two
   logic [15:0] mem [0:32767];
   logic [3:0] wait_q;

   // one access per request; stall adds idle cycles before the single-cycle ack
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mem_ack <= 1'b0;
         mem_rdata <= 16'h0000;
         wait_q <= 4'h0;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata; // read data is only meaningful with the ack
         if (mem_req && !mem_ack) begin
            if (wait_q < stall) begin
               wait_q <= wait_q + 4'h1;
            end else begin
               wait_q <= 4'h0;
               mem_ack <= 1'b1;
               if (mem_we) begin
                  mem[mem_addr[15:1]] <= mem_wdata;
               end else begin
                  mem_rdata <= mem[mem_addr[15:1]];
               end
            end
         end
      end
   end
endmodule

// file: sim/testbench.sv
// self-checking bench: each operation is driven and checked against a bench model
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
   import scc_pkg::*;
   localparam logic [15:0] DVT_BASE = 16'h0040;
   localparam logic [15:0] MON_BASE = 16'h2000;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic start = 1'b0;
   scc_op_type op = SCC_OP_NONE;
   logic [7:0] section_num = 8'h00;
   logic [4:0] level_num = 5'h00;
   logic [3:0] stall = 4'h0;
   logic [15:0] cur_p = 16'h0000;
   logic [15:0] cur_l = 16'h0000;
   logic [15:0] cur_g = 16'h0000;
   logic [15:0] cur_a = 16'h0000;
   logic [15:0] cur_e = 16'h0000;
   logic [15:0] cur_x = 16'h0000;
   logic [15:0] cur_ind = 16'h0000;
   logic mem_req, mem_we, mem_ack, busy, done;
   logic [15:0] mem_addr, mem_wdata, mem_rdata;
   logic [15:0] new_p, new_l, new_g, new_a, new_e, new_x, new_ind;
   logic [12:0] irq_config;
   logic [31:0] seed = 32'h7268;
   int n_fail = 0;
   int n_compared = 0;

   // 125 MHz system clock
   always #4 clk_sys = ~clk_sys;

   scc_unit #(.DEV_TABLE_BASE(DVT_BASE)) u_dut (
      .clk_sys(clk_sys), .nrst(nrst), .start(start), .op(op), .section_num(section_num),
      .level_num(level_num), .cur_p(cur_p), .cur_l(cur_l), .cur_g(cur_g), .cur_a(cur_a),
      .cur_e(cur_e), .cur_x(cur_x), .cur_ind(cur_ind), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .busy(busy), .done(done), .new_p(new_p), .new_l(new_l), .new_g(new_g), .new_a(new_a),
      .new_e(new_e), .new_x(new_x), .new_ind(new_ind), .irq_config(irq_config)
   );

   scc_mem_model u_mem (
      .clk_sys(clk_sys), .nrst(nrst), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .stall(stall), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata)
   );

   // sixteen shifts per call so successive values are not simple shifts of each other
   function automatic logic [15:0] rnd();
      for (int i = 0; i < 16; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[15:0];
   endfunction

   // backdoor access, used only while the unit is idle
   task automatic w(input logic [15:0] a, input logic [15:0] v);
      u_mem.mem[a[15:1]] = v;
   endtask

   function automatic logic [15:0] r(input logic [15:0] a);
      return u_mem.mem[a[15:1]];
   endfunction

   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // start one operation, optionally raise start again while busy, wait bounded for done
   task automatic run(input scc_op_type o, input logic poke);
      int k;
      @(posedge clk_sys);
      start <= 1'b1;
      op <= o;
      stall <= {2'b00, seed[5:4]};
      @(posedge clk_sys);
      start <= 1'b0;
      #1;
      k = 0;
      while (done !== 1'b1 && k < 400) begin
         @(posedge clk_sys);
         start <= poke && k == 3;
         k++;
         #1;
      end
      if (done !== 1'b1) begin
         n_fail++;
         complete_run();
      end
      @(posedge clk_sys);
      #1;
      `CHK(busy, 1'b0)
   endtask

   initial begin
      logic [15:0] g, p, l, ind, nn, lr, pr, lv, dv, ptr;
      logic [15:0] cx [7];
      logic [15:0] nv [7];
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(busy, 1'b0)
      `CHK(mem_req, 1'b0)
      `CHK(done, 1'b0)
      @(posedge clk_sys);
      nrst <= 1'b1;
      w(MON_RELOC_PTR_ADDR, MON_BASE);
      // a start with no operation must leave the unit idle
      @(posedge clk_sys);
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      #1;
      `CHK(busy, 1'b0)
      for (int i = 0; i < 15; i++) begin
         g = 16'h4000 | (rnd() & 16'h1FFE);
         p = rnd();
         l = rnd();
         ind = rnd();
         nn = (rnd() & 16'h000F) + 16'h0001;
         lr = 16'h0100 | (rnd() & 16'h00FE);
         pr = rnd() & 16'h3FFE;
         @(posedge clk_sys);
         cur_g <= g;
         cur_p <= p;
         cur_l <= l;
         cur_ind <= ind;
         section_num <= nn[7:0];
         case (i % 3)
            0: begin
               w(g - (nn << 2), lr);
               w(g - (nn << 2) + 16'h0002, pr);
               run(SCC_OP_CALL, 1'b0);
               `CHK(new_p, g + pr)
               `CHK(new_l, g + lr)
               `CHK(r(g + lr), p - g)
               `CHK(r(g + lr + 16'h0002), l - g)
               @(posedge clk_sys);
               cur_p <= g + pr;
               cur_l <= g + lr;
               run(SCC_OP_RET, 1'b0);
               `CHK(new_p, p)
               `CHK(new_l, l)
            end
            1: begin
               w(MON_BASE - (nn << 2), lr);
               w(MON_BASE - (nn << 2) + 16'h0002, pr);
               run(SCC_OP_SVC, 1'b0);
               `CHK(new_l, ZERO_WORD)
               `CHK(new_p, pr)
               `CHK(new_g, g)
               `CHK(new_ind[IND_MASTER], MASTER_MODE)
               `CHK(new_ind[IND_PROT], 1'b1)
               `CHK(r(g), p - g)
               `CHK(r(g + 16'h0002), l - g)
               `CHK(r(g + 16'h0004), ind)
               @(posedge clk_sys);
               cur_p <= new_p;
               cur_l <= new_l;
               cur_ind <= new_ind;
               run(SCC_OP_SVR, 1'b0);
               `CHK(new_p, p)
               `CHK(new_l, l)
               `CHK(new_ind[1:0], ind[1:0])
            end
            default: begin
               lv = rnd() & 16'h001F;
               dv = rnd();
               ptr = 16'h1000 + (lv << 4);
               level_num <= lv[4:0];
               w(DVT_BASE + (lv << 1), dv);
               w(DVT_BASE + 16'h0040 + (lv << 1), ptr);
               for (int k = 0; k < 7; k++) begin
                  cx[k] = rnd();
                  w(ptr + (k[15:0] << 1), cx[k]);
               end
               run(SCC_OP_ACT, 1'b1);
               nv = '{new_ind, new_x, new_e, new_a, new_g, new_l, new_p};
               for (int k = 0; k < 7; k++) `CHK(nv[k], cx[k])
               `CHK(irq_config, dv[15:3])
               for (int k = 0; k < 7; k++) cx[k] = rnd();
               @(posedge clk_sys);
               cur_ind <= cx[0];
               cur_x <= cx[1];
               cur_e <= cx[2];
               cur_a <= cx[3];
               cur_g <= cx[4];
               cur_l <= cx[5];
               cur_p <= cx[6];
               run(SCC_OP_SAVE, 1'b0);
               for (int k = 0; k < 7; k++) `CHK(r(ptr + (k[15:0] << 1)), cx[k])
               `CHK(irq_config, dv[15:3])
            end
         endcase
      end
      // a reset in mid-operation abandons it and clears the outputs
      @(posedge clk_sys);
      start <= 1'b1;
      op <= SCC_OP_ACT;
      repeat (3) @(posedge clk_sys);
      start <= 1'b0;
      nrst <= 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK(busy, 1'b0)
      `CHK(mem_req, 1'b0)
      `CHK(new_p, 16'h0000)
      @(posedge clk_sys);
      nrst <= 1'b1;
      // the context saved last must come back after the reset
      run(SCC_OP_ACT, 1'b0);
      nv = '{new_ind, new_x, new_e, new_a, new_g, new_l, new_p};
      for (int k = 0; k < 7; k++) `CHK(nv[k], cx[k])
      complete_run();
   end
endmodule
